//--- verilog/ddc_top.sv
// module: register file and enable decode of the dual converter control
// Behaviour
// - two 8-bit code registers, cleared at reset
// - control register resets and standby to 0x1f
// - low five control bits ignore writes, read one
// - bit 7 enables channel 1 convert and drive
// - bit 6 enables channel 0 convert and drive
// - bit 5 selects joint conversion control
// - conversion enable decode per table
// - pin drive follows own enable only
// - common enable keeps analog powered
// - data write restarts conversion of an enabled channel two clocks after the write
// - code passed unchanged to converter
// - output held until new code or standby
// - disabled channel pin becomes input
// - codes at ffa8, ffa9; control at ffaa
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module ddc_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic standby,
  input wire logic adc_start_bit,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic [7:0] analog_out0_pin_code,
  output logic [7:0] analog_out1_pin_code,
  output logic analog_out0_pin_strobe,
  output logic analog_out1_pin_strobe,
  output logic analog_out0_pin_active,
  output logic analog_out1_pin_active,
  output logic analog_out0_pin_oe,
  output logic analog_out1_pin_oe,
  output logic analog_power_on
);

  logic [7:0] code_reg [ddc_pkg::ddc_code_count];
  logic [2:0] control_reg;
  logic [7:0] control_view;
  logic [1:0] code_write;
  logic channel1_output_enable;
  logic channel0_output_enable;
  logic common_convert_enable;
  logic [1:0] convert_en;
  logic [1:0] drive_en;
  logic [7:0] ch_code [ddc_pkg::ddc_code_count];
  logic [1:0] ch_strobe;
  logic [1:0] ch_active;
  logic [1:0] ch_oe;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // byte addresses
  assign code_write[0] = wr && (addr == ddc_pkg::ddc_addr_code0);
  assign code_write[1] = wr && (addr == ddc_pkg::ddc_addr_code1);

  // ----------------------------------------
  // code registers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < ddc_pkg::ddc_code_count; gi++) begin : g_code
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          code_reg[gi] <= ddc_pkg::ddc_code_reset;
        end else if (standby) begin
          code_reg[gi] <= ddc_pkg::ddc_code_reset;
        end else if (code_write[gi]) begin
          code_reg[gi] <= wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // control reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      control_reg <= ddc_pkg::ddc_control_reset[7:5];
    end else if (standby) begin
      control_reg <= ddc_pkg::ddc_control_reset[7:5];
    end else if (wr && (addr == ddc_pkg::ddc_addr_control)) begin
      control_reg <= wdata[7:5];
    end
  end

  assign control_view = {control_reg, ddc_pkg::ddc_control_fixed_ones[4:0]};

  assign channel1_output_enable = control_view[ddc_pkg::ddc_bit_oe1];
  assign channel0_output_enable = control_view[ddc_pkg::ddc_bit_oe0];
  assign common_convert_enable = control_view[ddc_pkg::ddc_bit_common];

  // ----------------------------------------
  // enable decode
  // ----------------------------------------
  // conversion table
  always_comb begin
    convert_en[0] = channel0_output_enable ||
                    (common_convert_enable && channel1_output_enable);
    convert_en[1] = channel1_output_enable ||
                    (common_convert_enable && channel0_output_enable);
  end

  assign drive_en = {channel1_output_enable, channel0_output_enable};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      analog_power_on <= 1'b0;
    end else begin
      analog_power_on <= ~standby & (common_convert_enable | adc_start_bit |
                         channel0_output_enable | channel1_output_enable);
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= ddc_pkg::ddc_unmapped_read;
    end else if (rd) begin
      unique case (addr)
        ddc_pkg::ddc_addr_code0: begin
          rdata <= code_reg[0];
        end
        ddc_pkg::ddc_addr_code1: begin
          rdata <= code_reg[1];
        end
        ddc_pkg::ddc_addr_control: begin
          rdata <= control_view;
        end
        default: begin
          rdata <= ddc_pkg::ddc_unmapped_read;
        end
      endcase
    end else begin
      rdata <= ddc_pkg::ddc_unmapped_read;
    end
  end

  // ----------------------------------------
  // channel slices
  // ----------------------------------------
  generate
    for (gi = 0; gi < ddc_pkg::ddc_code_count; gi++) begin : g_ch
      ddc_conv_if conv ();
      assign conv.convert_enable = convert_en[gi];
      assign conv.pin_drive = drive_en[gi];
      assign conv.code = code_reg[gi];
      assign conv.restart = code_write[gi];
      ddc_channel u_ch (
        .mclk(mclk),
        .rst(rst),
        .standby(standby),
        .conv(conv),
        .analog_code(ch_code[gi]),
        .analog_strobe(ch_strobe[gi]),
        .analog_active(ch_active[gi]),
        .analog_pin_oe(ch_oe[gi])
      );
    end
  endgenerate

  assign analog_out0_pin_oe = ch_oe[0];
  assign analog_out1_pin_oe = ch_oe[1];
  assign analog_out0_pin_code = ch_code[0];
  assign analog_out1_pin_code = ch_code[1];
  assign analog_out0_pin_strobe = ch_strobe[0];
  assign analog_out1_pin_strobe = ch_strobe[1];
  assign analog_out0_pin_active = ch_active[0];
  assign analog_out1_pin_active = ch_active[1];

endmodule : ddc_top

//--- verilog/ddc_pkg.sv
// package: register map and reset values of the dual converter control
package ddc_pkg;

  localparam logic [15:0] ddc_addr_code0 = 16'hffa8;
  localparam logic [15:0] ddc_addr_code1 = 16'hffa9;
  localparam logic [15:0] ddc_addr_control = 16'hffaa;

  localparam logic [7:0] ddc_code_reset = 8'h00;
  localparam logic [7:0] ddc_control_reset = 8'h1f;
  localparam logic [7:0] ddc_control_fixed_ones = 8'h1f;
  localparam logic [7:0] ddc_unmapped_read = 8'h00;

  localparam int ddc_bit_oe1 = 7;
  localparam int ddc_bit_oe0 = 6;
  localparam int ddc_bit_common = 5;

  localparam int ddc_code_count = 2;

endpackage : ddc_pkg

//--- verilog/ddc_conv_if.sv
// interface: per-channel drive to the analog converter slices
`timescale 1ns/1ps
interface ddc_conv_if;
  logic convert_enable;
  logic pin_drive;
  logic [7:0] code;
  logic restart;

  modport ctrl (
    output convert_enable,
    output pin_drive,
    output code,
    output restart
  );
  modport slice (
    input convert_enable,
    input pin_drive,
    input code,
    input restart
  );
endinterface : ddc_conv_if

//--- verilog/ddc_channel.sv
// module: one converter channel output stage
`timescale 1ns/1ps
module ddc_channel (
  input wire logic mclk,
  input wire logic rst,
  input wire logic standby,
  ddc_conv_if.slice conv,
  output logic [7:0] analog_code,
  output logic analog_strobe,
  output logic analog_active,
  output logic analog_pin_oe
);

  logic restart_reg;

  // ----------------------------------------
  // converter code and restart
  // ----------------------------------------
  // code unchanged
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      analog_code <= ddc_pkg::ddc_code_reset;
    end else if (standby) begin
      analog_code <= ddc_pkg::ddc_code_reset;
    end else begin
      analog_code <= conv.code;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= conv.restart & conv.convert_enable & ~standby;
    end
  end

  // strobe lines up with the new code, not the old one
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      analog_strobe <= 1'b0;
    end else begin
      analog_strobe <= restart_reg & ~standby;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      analog_active <= 1'b0;
    end else begin
      analog_active <= conv.convert_enable & ~standby;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // release pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      analog_pin_oe <= 1'b0;
    end else begin
      analog_pin_oe <= conv.pin_drive & ~standby;
    end
  end

endmodule : ddc_channel

//--- tb/ddc_load_model.sv
// model: analog output stage loading one converter channel
`timescale 1ns/1ps
module ddc_load_model (
  input wire logic mclk,
  input wire logic [7:0] code,
  input wire logic active,
  input wire logic oe,
  output logic [7:0] level
);
  logic [7:0] held_reg;
  always_ff @(posedge mclk) begin
    if (active) begin
      held_reg <= code;
    end
  end
  assign level = oe ? held_reg : ~held_reg;
endmodule : ddc_load_model

//--- tb/ddc_top_monitor.sv
// checker: port relations of the converter control block
`timescale 1ns/1ps
module ddc_top_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic standby,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] analog_out0_pin_code,
  input wire logic analog_out0_pin_strobe,
  input wire logic analog_out0_pin_active,
  input wire logic analog_out1_pin_active,
  input wire logic analog_out0_pin_oe,
  input wire logic analog_out1_pin_oe,
  input wire logic analog_power_on
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_ctl_wr;
    wr && addr == 16'hffaa && !standby ##1 !standby;
  endsequence
  sequence s_code0_wr;
    wr && addr == 16'hffa8 && !standby ##1 analog_out0_pin_active && !standby;
  endsequence
  AST_RD_IDLE: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside read");
  AST_RD_CTRL: assert property (
    rd && addr == 16'hffaa |=> rdata[4:0] == 5'h1f)
    else $error("control low bits not ones");
  AST_OE1: assert property (
    s_ctl_wr |=> analog_out1_pin_oe == $past(wdata[7], 2))
    else $error("channel 1 drive not from bit 7");
  AST_OE0: assert property (
    s_ctl_wr |=> analog_out0_pin_oe == $past(wdata[6], 2))
    else $error("channel 0 drive not from bit 6");
  AST_CODE0: assert property (
    s_code0_wr |=> analog_out0_pin_strobe &&
    analog_out0_pin_code == $past(wdata, 2))
    else $error("code write not restarted");
  AST_NOSTB: assert property (
    !(wr && addr == 16'hffa8) |-> ##2 !analog_out0_pin_strobe)
    else $error("restart without code write");
  AST_ACT0: assert property (
    analog_out0_pin_oe |-> analog_out0_pin_active)
    else $error("enabled channel 0 idle");
  AST_OFF: assert property (
    !analog_out0_pin_oe && !analog_out1_pin_oe |->
    !analog_out0_pin_active && !analog_out1_pin_active)
    else $error("conversion with both enables clear");
  AST_PWR: assert property (
    analog_out0_pin_oe || analog_out1_pin_oe |-> analog_power_on)
    else $error("analog power off while driving");
  AST_STBY: assert property (
    standby ##1 standby |=> !analog_out0_pin_oe &&
    analog_out0_pin_code == 8'h00)
    else $error("standby did not clear");
endmodule : ddc_top_monitor
bind ddc_top ddc_top_monitor i_ddc_top_monitor (.mclk(mclk), .rst(rst),
  .standby(standby), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .analog_out0_pin_code(analog_out0_pin_code),
  .analog_out0_pin_strobe(analog_out0_pin_strobe),
  .analog_out0_pin_active(analog_out0_pin_active),
  .analog_out1_pin_active(analog_out1_pin_active),
  .analog_out0_pin_oe(analog_out0_pin_oe),
  .analog_out1_pin_oe(analog_out1_pin_oe),
  .analog_power_on(analog_power_on));

//--- tb/ddc_top_tb.sv
// testbench: registers and enable decode of the converter control
`timescale 1ns/1ps
module ddc_top_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic standby = 1'b0;
  logic adc = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, code0, code1, lvl0;
  logic s0, s1, a0, a1, o0, o1, pwr;
  int miscompares = 0;
  int total_checks = 0;
  logic [7:0] cv [7] = '{8'h00, 8'h40, 8'h60, 8'h80, 8'ha0, 8'hc0, 8'h20};
  logic [4:0] ev [7] = '{5'h00, 5'h0b, 5'h0f, 5'h15, 5'h17, 5'h1f, 5'h01};
  always #2.5 mclk = ~mclk;
  ddc_top i_ddc_top (.mclk(mclk), .rst(rst), .standby(standby),
    .adc_start_bit(adc), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .analog_out0_pin_code(code0),
    .analog_out1_pin_code(code1), .analog_out0_pin_strobe(s0),
    .analog_out1_pin_strobe(s1), .analog_out0_pin_active(a0),
    .analog_out1_pin_active(a1), .analog_out0_pin_oe(o0),
    .analog_out1_pin_oe(o1), .analog_power_on(pwr));
  ddc_load_model i_ddc_load_model (.mclk(mclk), .code(code0),
    .active(a0), .oe(o0), .level(lvl0));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_t(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_t
  task automatic rd_t(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_t
  task automatic settle;
    @(posedge mclk);
    #1;
  endtask : settle
  task automatic t_reset;
    rd_t(16'hffa8, 8'h00);
    rd_t(16'hffa9, 8'h00);
    rd_t(16'hffaa, 8'h1f);
    rd_t(16'hffab, 8'h00);
  endtask : t_reset
  task automatic t_decode;
    for (int i = 0; i < 7; i++) begin
      wr_t(16'hffaa, cv[i]);
      settle();
      chk(8'({o1, o0, a1, a0, pwr}), 8'(ev[i]));
      rd_t(16'hffaa, cv[i] | 8'h1f);
    end
    @(posedge mclk);
    adc <= 1'b1;
    wr_t(16'hffaa, 8'h00);
    settle();
    chk(8'(pwr), 8'h01);
    @(posedge mclk);
    adc <= 1'b0;
    settle();
    chk(8'(pwr), 8'h00);
  endtask : t_decode
  task automatic t_code;
    wr_t(16'hffaa, 8'h40);
    wr_t(16'hffa8, 8'h5a);
    settle();
    chk(8'({s0, s1}), 8'h02);
    chk(code0, 8'h5a);
    settle();
    chk(8'(s0), 8'h00);
    chk(lvl0, 8'h5a);
    wr_t(16'hffa9, 8'ha5);
    settle();
    chk(8'(s1), 8'h00);
    chk(code1, 8'ha5);
    rd_t(16'hffa9, 8'ha5);
    wr_t(16'hffaa, 8'h60);
    wr_t(16'hffa9, 8'h3c);
    settle();
    chk(8'({s0, s1}), 8'h01);
    chk(8'({o1, a1}), 8'h01);
    chk(code1, 8'h3c);
    wr_t(16'hffaa, 8'h00);
    settle();
    chk(lvl0, 8'ha5);
  endtask : t_code
  task automatic t_stby;
    wr_t(16'hffa8, 8'hff);
    wr_t(16'hffaa, 8'hc0);
    standby <= 1'b1;
    repeat (2) @(posedge mclk);
    standby <= 1'b0;
    rd_t(16'hffa8, 8'h00);
    rd_t(16'hffaa, 8'h1f);
  endtask : t_stby
  task automatic end_sim;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_decode();
    t_code();
    t_stby();
    end_sim();
  end
  initial begin
    #5000;
    miscompares++;
    end_sim();
  end
endmodule : ddc_top_tb
